// >>> tx_ctl_pkg.sv
// Purpose: Constants for the transmit FIFO and clock select block
// Assumes: 20 MHz system clock, Wishbone classic register access
// Notes:   Control bits stand in for the pin straps
package tx_ctl_pkg;
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STAT   = 8'h04;
  // Control field positions
  localparam int         CTL_FREQ   = 0;
  localparam int         CTL_SRC    = 1;
  localparam int         CTL_LKEN   = 2;
  localparam int         CTL_BW     = 3;
  localparam int         CTL_AUXDIS = 4;
  localparam int         CTL_FRST   = 5;
  localparam int         CTL_AUTO   = 6;
  localparam int         CTL_W      = 7;
  // Pull-up on frequency select, pull-downs elsewhere
  localparam logic [6:0] CTRL_RST   = 7'h01;
  // Reference rates in kHz, standard rate
  localparam int         REF_LO_KHZ = 77760;
  localparam int         REF_HI_KHZ = 155520;
  localparam int         PAR_KHZ    = 622080;
  // System cycles per parallel word
  localparam int         OUT_DIV    = 4;
  // Parallel clocks per auxiliary clock period
  localparam int         AUX_RATIO  = PAR_KHZ / REF_HI_KHZ;
  // Lock detector windows and acquisition counts
  localparam int         CNT_W      = 5;
  localparam int         GAP_HI     = 8;
  localparam int         GAP_LO     = GAP_HI * REF_HI_KHZ / REF_LO_KHZ;
  localparam int         ACQ_WIDE   = 4;
  localparam int         BW_RATIO   = 4;
  localparam int         ACQ_NARROW = ACQ_WIDE * BW_RATIO;
  // Output clock periods spent draining
  localparam int         FLUSH_TICKS = 9;
  // Flush sequencer states
  typedef enum logic [2:0] {
    FL_RUN   = 3'b001,
    FL_HOLD  = 3'b010,
    FL_DRAIN = 3'b100
  } flush_e;
endpackage

// >>> lock_if.sv
`timescale 1ns/1ps
// Purpose: Carrier between the top and one lock detector
// Assumes: All members on the system clock
// Notes:   ctl side drives settings, det side answers lock
interface lock_if;
  logic                         ref_lvl;   // Synchronized ref level
  logic                         enable;    // Detector enable
  logic [tx_ctl_pkg::CNT_W-1:0] gap_limit; // Longest legal gap
  logic [tx_ctl_pkg::CNT_W-1:0] acq_count; // Edges needed to lock
  logic                         locked;    // Registered lock
  modport det (input ref_lvl, enable, gap_limit, acq_count,
               output locked);
  modport ctl (output ref_lvl, enable, gap_limit, acq_count,
               input locked);
endinterface

// >>> ref_lock_det.sv
`timescale 1ns/1ps
// Purpose: Activity lock detector for one reference clock
// Assumes: ref_lvl already passed two flip-flops
// Notes:   Lock after acq_count good edges, lost on long gap
module ref_lock_det (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  lock_if.det       lk
);
  localparam int W = tx_ctl_pkg::CNT_W;
  logic         prev_q, prev_d; // Previous level for edge find
  logic [W-1:0] gap_q, gap_d;   // Cycles since last edge
  logic [W-1:0] good_q, good_d; // Good edges in a row
  logic         lock_q, lock_d; // Lock state
  logic         edge_w;         // Rising edge seen

  assign edge_w = lk.ref_lvl && !prev_q;

  ////////////////////////////////////////////////////////////////
  // Next state: count edges, drop on a stalled reference
  always_comb begin
    prev_d = lk.ref_lvl;
    gap_d  = gap_q;
    good_d = good_q;
    if (!lk.enable) begin
      // Disabled detector forgets everything
      gap_d  = '0;
      good_d = '0;
    end else if (edge_w) begin
      gap_d = '0;
      if (good_q != '1) begin
        good_d = good_q + 1'b1;
      end
    end else if (gap_q >= lk.gap_limit) begin
      // Reference stalled: out of lock
      good_d = '0;
    end else begin
      gap_d = gap_q + 1'b1;
    end
    lock_d = lk.enable && (good_d >= lk.acq_count);
  end

  // Registers only
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_q <= 1'b0;
      gap_q  <= '0;
      good_q <= '0;
      lock_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      gap_q  <= gap_d;
      good_q <= good_d;
      lock_q <= lock_d;
    end
  end

  assign lk.locked = lock_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  lock_lost_gap_a: assert property (
    (lk.enable && !edge_w && gap_q >= lk.gap_limit) |=> !lk.locked)
    else $error("lock held across stalled reference");

  lock_off_dis_a: assert property (
    !lk.enable |=> !lk.locked)
    else $error("lock shown while detector disabled");
endmodule

// >>> tx_fifo_and_refclk_select.sv
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
// Purpose: Transmit FIFO, flush control, reference select, clocks
// Assumes: All pin inputs asynchronous, sampled by two flip-flops
// Notes:   Word slot and output clock period are OUT_DIV cycles
module tx_fifo_and_refclk_select #(
  parameter int DEPTH = 8 // FIFO words
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_ref_clock_in,
  input  wire logic        i_dejitter_osc_clock_in,
  input  wire logic        i_tx_parallel_clock_in,
  input  wire logic [3:0]  i_tx_parallel_data_in,
  output logic             o_tx_serial_data,
  output logic             o_tx_parallel_clock_out,
  output logic             o_tx_aux_clock_out,
  output logic             o_multiplier_locked,
  output logic             o_dejitter_pll_locked,
  output logic             o_overflow
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = 7; // Synchronized bits
  localparam logic [3:0] TICKS =
    4'(tx_ctl_pkg::FLUSH_TICKS);

  ////////////////////////////////////////////////////////////////
  // Input synchronizers
  logic [SW-1:0] sync1_q, sync1_d; // First stage, read by second
  logic [SW-1:0] sync2_q, sync2_d; // Safe stage
  logic          pclk3_q, pclk3_d; // Previous parallel clock

  always_comb begin
    sync1_d = {i_tx_parallel_data_in, i_tx_parallel_clock_in,
               i_dejitter_osc_clock_in, i_ref_clock_in};
    sync2_d = sync1_q;
    pclk3_d = sync2_q[2];
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      pclk3_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      pclk3_q <= pclk3_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register bus: control word and status
  logic [6:0]  ctrl_q, ctrl_d; // Control bits
  logic        ack_q, ack_d;   // Bus acknowledge
  logic [31:0] rdat_q, rdat_d; // Read data
  logic [7:0]  stat_w;         // Status byte
  logic [AW:0] lvl_w;          // FIFO fill level
  logic        ovf_q, ovf_d;   // Overflow flag
  tx_ctl_pkg::flush_e st_q, st_d;

  assign stat_w = 8'({lvl_w, (st_q != tx_ctl_pkg::FL_RUN), ovf_q,
                      o_dejitter_pll_locked, o_multiplier_locked});

  // Ack one cycle after the strobe; write lands on the ack edge
  always_comb begin
    ack_d  = i_wb_cyc && i_wb_stb && !ack_q;
    ctrl_d = ctrl_q;
    rdat_d = rdat_q;
    if (ack_d && !i_wb_we) begin
      if (i_wb_adr == tx_ctl_pkg::ADR_CTRL) begin
        rdat_d = 32'(ctrl_q);
      end else if (i_wb_adr == tx_ctl_pkg::ADR_STAT) begin
        rdat_d = 32'(stat_w);
      end else begin
        // Unmapped reads answer zero
        rdat_d = '0;
      end
    end
    if (ack_q && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0] &&
        i_wb_adr == tx_ctl_pkg::ADR_CTRL) begin
      ctrl_d = i_wb_dat[6:0];
    end
  end

  // Control reset mirrors pin pulls
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= tx_ctl_pkg::CTRL_RST;
      ack_q  <= 1'b0;
      rdat_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Reference selection and lock detectors
  lock_if cmu_lk ();
  lock_if vco_lk ();

  always_comb begin
    // Multiplier fed from reference or oscillator
    cmu_lk.ref_lvl = ctrl_q[tx_ctl_pkg::CTL_SRC] ?
                     sync2_q[1] : sync2_q[0];
    cmu_lk.enable  = 1'b1;
    // Slower reference gives a wider gap window
    cmu_lk.gap_limit = ctrl_q[tx_ctl_pkg::CTL_FREQ] ?
      5'(tx_ctl_pkg::GAP_HI) : 5'(tx_ctl_pkg::GAP_LO);
    // Narrow band settles four times slower
    cmu_lk.acq_count = ctrl_q[tx_ctl_pkg::CTL_BW] ?
      5'(tx_ctl_pkg::ACQ_NARROW) : 5'(tx_ctl_pkg::ACQ_WIDE);
    vco_lk.ref_lvl   = sync2_q[1];
    vco_lk.enable    = ctrl_q[tx_ctl_pkg::CTL_LKEN] &&
                       ctrl_q[tx_ctl_pkg::CTL_SRC];
    vco_lk.gap_limit = cmu_lk.gap_limit;
    vco_lk.acq_count = cmu_lk.acq_count;
  end

  ref_lock_det u_cmu_det (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .lk        (cmu_lk.det)
  );

  ref_lock_det u_vco_det (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .lk        (vco_lk.det)
  );

  ////////////////////////////////////////////////////////////////
  // Output clock generation from the multiplier divider
  logic [1:0] div_q, div_d; // Word slot phase
  logic [1:0] aux_q, aux_d; // Auxiliary divider
  logic       pco_q, pco_d; // Parallel clock out
  logic       axo_q, axo_d; // Auxiliary clock out
  logic       tick_w;       // Last cycle of a word slot

  assign tick_w = (div_q == 2'(tx_ctl_pkg::OUT_DIV - 1));

  always_comb begin
    div_d = div_q + 2'h1;
    aux_d = tick_w ? aux_q + 2'h1 : aux_q;
    // High in the slot's second half, so the reset level is in phase
    pco_d = div_d[1];
    // Held low while disabled; no half pulses matter here
    axo_d = !ctrl_q[tx_ctl_pkg::CTL_AUXDIS] &&
            aux_d[1];
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_q <= 2'h0;
      aux_q <= 2'h0;
      pco_q <= 1'b0;
      axo_q <= 1'b0;
    end else begin
      div_q <= div_d;
      aux_q <= aux_d;
      pco_q <= pco_d;
      axo_q <= axo_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Flush sequencer
  logic [3:0] tk_q, tk_d; // Output periods left to drain
  logic       frst_w;     // Manual FIFO reset bit
  logic       run_w;      // FIFO passing data
  logic       done_w;     // Drain finishes this cycle

  assign frst_w = ctrl_q[tx_ctl_pkg::CTL_FRST];
  assign run_w  = (st_q == tx_ctl_pkg::FL_RUN);
  assign done_w = (st_q == tx_ctl_pkg::FL_DRAIN) && !frst_w &&
                  tick_w && (tk_q == 4'h1);

  always_comb begin
    st_d = st_q;
    tk_d = tk_q;
    unique case (st_q)
      tx_ctl_pkg::FL_RUN: begin
        if (frst_w) begin
          st_d = tx_ctl_pkg::FL_HOLD;
        end else if (ctrl_q[tx_ctl_pkg::CTL_AUTO] && ovf_q) begin
          st_d = tx_ctl_pkg::FL_DRAIN;
          tk_d = TICKS;
        end
      end
      tx_ctl_pkg::FL_HOLD: begin
        if (!frst_w) begin
          st_d = tx_ctl_pkg::FL_DRAIN;
          tk_d = TICKS;
        end
      end
      tx_ctl_pkg::FL_DRAIN: begin
        if (frst_w) begin
          st_d = tx_ctl_pkg::FL_HOLD;
        end else if (done_w) begin
          st_d = tx_ctl_pkg::FL_RUN;
        end else if (tick_w) begin
          tk_d = tk_q - 4'h1;
        end
      end
      default: begin
        st_d = tx_ctl_pkg::FL_HOLD;
      end
    endcase
  end

  // Power-up starts with a drain so stale words never leave
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= tx_ctl_pkg::FL_DRAIN;
      tk_q <= TICKS;
    end else begin
      st_q <= st_d;
      tk_q <= tk_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // FIFO storage, pointers and serializer
  logic [3:0]  mem [DEPTH]; // Word storage
  logic [AW:0] wp_q, wp_d;  // Write pointer, wrap bit on top
  logic [AW:0] rp_q, rp_d;  // Read pointer
  logic [3:0]  sh_q, sh_d;  // Serializer shift
  logic        ser_q, ser_d;
  logic        wr_w, push_w, pop_w, full_w;

  assign lvl_w  = wp_q - rp_q;
  assign full_w = (lvl_w == (AW+1)'(DEPTH));
  assign wr_w   = sync2_q[2] && !pclk3_q;
  assign push_w = wr_w && run_w && !full_w;
  assign pop_w  = tick_w && run_w && (lvl_w != '0);

  always_comb begin
    wp_d  = run_w ? wp_q + (AW+1)'(push_w) : '0;
    rp_d  = run_w ? rp_q + (AW+1)'(pop_w) : '0;
    ovf_d = done_w ? 1'b0 : ovf_q;
    if (wr_w && run_w && full_w) begin
      ovf_d = 1'b1;
    end
    if (tick_w) begin
      // Idle slots send zeros
      sh_d = pop_w ? mem[rp_q[AW-1:0]] : 4'h0;
    end else begin
      sh_d = {sh_q[2:0], 1'b0};
    end
    ser_d = sh_d[3];
  end

  always_ff @(posedge i_sys_clk) begin
    if (push_w) begin
      mem[wp_q[AW-1:0]] <= sync2_q[6:3];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      ovf_q <= 1'b0;
      sh_q  <= 4'h0;
      ser_q <= 1'b0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      ovf_q <= ovf_d;
      sh_q  <= sh_d;
      ser_q <= ser_d;
    end
  end

  assign o_wb_dat                = rdat_q;
  assign o_wb_ack                = ack_q;
  assign o_tx_serial_data        = ser_q;
  assign o_tx_parallel_clock_out = pco_q;
  assign o_tx_aux_clock_out      = axo_q;
  assign o_multiplier_locked     = cmu_lk.locked;
  assign o_dejitter_pll_locked   = vco_lk.locked;
  assign o_overflow              = ovf_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // Bits of the word loaded at the slot edge, msb first
  sequence word_msb_s;
    (o_tx_serial_data == $past(sh_d[3])) ##1
    (o_tx_serial_data == $past(sh_d[2], 2)) ##1
    (o_tx_serial_data == $past(sh_d[1], 3)) ##1
    (o_tx_serial_data == $past(sh_d[0], 4));
  endsequence
  sequence drain_s;
    (st_q == tx_ctl_pkg::FL_DRAIN) ##[30:40]
    (st_q == tx_ctl_pkg::FL_RUN);
  endsequence
  // Rest of one output clock period after a rise
  sequence pclk_cycle_s;
    o_tx_parallel_clock_out ##1 (!o_tx_parallel_clock_out)[*2]
    ##1 o_tx_parallel_clock_out;
  endsequence

  ser_order_a: assert property (
    tick_w |=> word_msb_s)
    else $error("serial bits not msb first");
  flush_time_a: assert property (
    ($fell(frst_w) && st_q == tx_ctl_pkg::FL_HOLD &&
     !ctrl_q[tx_ctl_pkg::CTL_FRST]) |=> drain_s)
    else $error("flush did not end in time");
  // Pointers clear one cycle after the hold state is entered
  hold_fifo_a: assert property (
    frst_w |=> (st_q == tx_ctl_pkg::FL_HOLD)
    ##1 (wp_q == '0 && rp_q == '0))
    else $error("fifo not held in reset");
  auto_flush_a: assert property (
    (run_w && ovf_q && !frst_w && ctrl_q[tx_ctl_pkg::CTL_AUTO])
    |=> (st_q == tx_ctl_pkg::FL_DRAIN))
    else $error("auto recovery did not start");
  ovf_sticky_a: assert property (
    (o_overflow && !done_w) |=> o_overflow)
    else $error("overflow dropped before flush");
  ovf_set_a: assert property (
    (wr_w && run_w && full_w) |=> o_overflow)
    else $error("overflow not raised on full write");
  word_capture_a: assert property (
    (push_w && !pop_w) |=> (lvl_w == $past(lvl_w) + 1'b1))
    else $error("captured word not stored");
  pclk_period_a: assert property (
    $rose(o_tx_parallel_clock_out) |=> pclk_cycle_s)
    else $error("parallel clock period wrong");
  aux_off_a: assert property (
    ctrl_q[tx_ctl_pkg::CTL_AUXDIS] |=> !o_tx_aux_clock_out)
    else $error("aux clock active while disabled");
  vco_gate_a: assert property (
    !(ctrl_q[tx_ctl_pkg::CTL_LKEN] && ctrl_q[tx_ctl_pkg::CTL_SRC])
    |=> ##1 !o_dejitter_pll_locked)
    else $error("de-jitter lock shown while gated");
endmodule

// >>> framer_model.sv
`timescale 1ns/1ps
// Purpose: Upstream framer that drives parallel words and the word clock
// Assumes: Bench changes i_run and i_fast just after a clock edge
// Notes:   Word clock stands low between words; idle lanes show ~last
module framer_model (
  input  wire logic       i_sys_clk, // System clock
  input  wire logic       i_run,     // Keep sending words
  input  wire logic       i_fast,    // Period of 2 cycles, overflow tests
  input  wire logic [3:0] i_word,    // Word to send
  output logic            o_pclk,    // Word clock
  output logic      [3:0] o_data     // Word lanes
);
  logic [1:0] ph;  // Phase within one word period
  logic       act; // A word period is in progress

  initial begin
    ph = 2'h0;
    act = 1'b0;
    o_data = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock high in the second half, so lanes settle well before the rise
  assign o_pclk = act && (i_fast ? (ph == 2'h1) : ph[1]);

  // Lanes change together at the start of each word period
  always @(posedge i_sys_clk) begin
    if (act && ph != (i_fast ? 2'h1 : 2'h3)) begin
      ph <= ph + 2'h1;
    end else if (i_run) begin
      act <= 1'b1;
      ph <= 2'h0;
      o_data <= i_word;
    end else if (act) begin
      // Released lanes must not keep showing the last word
      act <= 1'b0;
      o_data <= ~o_data;
    end
  end
endmodule

// >>> tx_fifo_and_refclk_select_tb_top.sv
`timescale 1ns/1ps
// Purpose: Self-checking bench for the transmit FIFO and clock select
// Assumes: CTRL at 0x00, STATUS at 0x04, ack one cycle after request
// Notes:   Reference clocks are made here as slow levels on the sys clock
module tx_fifo_and_refclk_select_tb_top;
  logic        clk, nrst, cyc, stb, we, ack;   // Clock, reset, bus
  logic [7:0]  adr;                           // Bus address
  logic [3:0]  sel, pdata, word;              // Byte lanes, partner lanes
  logic [31:0] wdat, rdat, q;                 // Bus data
  logic [1:0]  rclk;                          // Normal and osc references
  logic        pclk_in, ser, pclk_out, aux;   // Link and clock pins
  logic        mlock, dlock, ovf, run, fast;  // Status pins, partner ctl
  logic        seen;                          // Probe word found in stream
  logic [11:0] hist;                          // Recent serial bits
  int          half[2], cnt[2];               // Reference half periods
  int          error_cnt, compares;           // Report counters
  int          np, na;                        // Clock rise counts

  tx_fifo_and_refclk_select #(.DEPTH(8)) dut_u (
    .i_sys_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_ref_clock_in(rclk[0]),
    .i_dejitter_osc_clock_in(rclk[1]), .i_tx_parallel_clock_in(pclk_in),
    .i_tx_parallel_data_in(pdata), .o_tx_serial_data(ser),
    .o_tx_parallel_clock_out(pclk_out), .o_tx_aux_clock_out(aux),
    .o_multiplier_locked(mlock), .o_dejitter_pll_locked(dlock),
    .o_overflow(ovf));

  framer_model part_u (.i_sys_clk(clk), .i_run(run), .i_fast(fast),
    .i_word(word), .o_pclk(pclk_in), .o_data(pdata));

  ////////////////////////////////////////////////////////////////////////
  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Reference toggles; a half period of 0 stops that reference
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (half[i] != 0 && cnt[i] >= half[i] - 1) begin
        cnt[i] <= 0;
        rclk[i] <= ~rclk[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end

  // Serial watch: a probe word framed by empty slots, first bit oldest
  always @(posedge clk) begin
    hist <= {hist[10:0], ser};
    if (hist == 12'b0000_1011_0000) begin
      seen <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One classic cycle; released only at the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic wr_ctrl(input logic [7:0] d);
    wb(1'b1, tx_ctl_pkg::ADR_CTRL, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic wait_ovf(input logic v);
    int n;
    n = 0;
    while (ovf !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (ovf !== v) begin
      error_cnt++;
      end_sim();
    end
  endtask

  // Rising edges of both output clocks over 64 cycles
  task automatic rises();
    logic lp, la;
    np = 0;
    na = 0;
    lp = pclk_out;
    la = aux;
    repeat (64) begin
      @(posedge clk);
      np += int'(pclk_out === 1'b1 && lp === 1'b0);
      na += int'(aux === 1'b1 && la === 1'b0);
      lp = pclk_out;
      la = aux;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {nrst, cyc, stb, we, run, fast, seen} = 7'h00;
    {adr, sel, wdat, word, hist, rclk} = 62'h0;
    half = '{0, 0};
    cnt = '{0, 0};
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(tx_ctl_pkg::ADR_CTRL, 32'h01);
    rd(8'h08, 32'h0);
    // Writes to status and to an unmapped address change nothing
    wb(1'b1, tx_ctl_pkg::ADR_STAT, 32'h0000007e);
    wb(1'b1, 8'h08, 32'h0000007e);
    rd(tx_ctl_pkg::ADR_CTRL, 32'h01);
    // Manual flush, held across two output clock periods and a status read
    wr_ctrl(8'h21);
    repeat (8) @(posedge clk);
    rd(tx_ctl_pkg::ADR_STAT, 32'h08);
    wr_ctrl(8'h01);
    repeat (26) @(posedge clk);
    rd(tx_ctl_pkg::ADR_STAT, 32'h08);
    repeat (12) @(posedge clk);
    rd(tx_ctl_pkg::ADR_STAT, 32'h00);
    // Output clocks, then auxiliary disabled
    rises();
    chk(np, 16);
    chk(na, 4);
    wr_ctrl(8'h11);
    repeat (4) @(posedge clk);
    rises();
    chk(na, 0);
    chk(aux, 1'b0);
    // Multiplier lock on the normal reference
    wr_ctrl(8'h01);
    half[0] <= 2;
    repeat (40) @(posedge clk);
    chk(mlock, 1'b1);
    chk(dlock, 1'b0);
    half[0] <= 0;
    repeat (24) @(posedge clk);
    chk(mlock, 1'b0);
    // Slow reference locks only at the lower frequency setting
    half[0] <= 6;
    repeat (80) @(posedge clk);
    chk(mlock, 1'b0);
    wr_ctrl(8'h00);
    repeat (80) @(posedge clk);
    chk(mlock, 1'b1);
    // Narrow bandwidth needs four times the edges
    half[0] <= 0;
    repeat (24) @(posedge clk);
    wr_ctrl(8'h09);
    half[0] <= 2;
    repeat (40) @(posedge clk);
    chk(mlock, 1'b0);
    repeat (40) @(posedge clk);
    chk(mlock, 1'b1);
    // Oscillator source and its lock output
    half[0] <= 0;
    half[1] <= 2;
    wr_ctrl(8'h03);
    repeat (40) @(posedge clk);
    chk(mlock, 1'b1);
    chk(dlock, 1'b0);
    wr_ctrl(8'h07);
    repeat (40) @(posedge clk);
    chk(dlock, 1'b1);
    wr_ctrl(8'h05);
    repeat (40) @(posedge clk);
    chk(dlock, 1'b0);
    chk(mlock, 1'b0);
    // One probe word through the FIFO to the serial pin
    wr_ctrl(8'h01);
    word <= 4'hb;
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    repeat (40) @(posedge clk);
    chk(seen, 1'b1);
    // Overrun with manual recovery
    fast <= 1'b1;
    run <= 1'b1;
    wait_ovf(1'b1);
    run <= 1'b0;
    repeat (60) @(posedge clk);
    chk(ovf, 1'b1);
    rd(tx_ctl_pkg::ADR_STAT, 32'h04);
    wr_ctrl(8'h21);
    repeat (8) @(posedge clk);
    chk(ovf, 1'b1);
    wr_ctrl(8'h01);
    repeat (44) @(posedge clk);
    chk(ovf, 1'b0);
    // Overrun with automatic recovery
    wr_ctrl(8'h41);
    run <= 1'b1;
    wait_ovf(1'b1);
    run <= 1'b0;
    repeat (48) @(posedge clk);
    chk(ovf, 1'b0);
    end_sim();
  end
endmodule
